// [ccpts_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module ccpts_unit
  import ccpts_pkg::*;
#(
  parameter int OWN_CHANNEL = 0
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire ccpts_ptmr_t [NUM_PTMR-1:0]  period_timers,
  input  wire logic [15:0]                 companion_wide_timer,
  input  wire logic                        capture_pin,
  output logic                             unit_out,
  output logic                             pin_out,
  output logic                             pin_oe,
  output ccpts_route_t                     consumers,
  output logic                             companion_clear,
  output logic      [NUM_PTMR-1:0]         period_clear,
  output ccpts_tsel_t                      timer_choices
);

  logic [7:0]  control_q;
  logic [7:0]  tsel_one_q;
  logic [7:0]  tsel_two_q;
  logic [7:0]  val_low_q;
  logic [7:0]  val_high_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        out_q;
  logic        oe_q;
  logic        comp_clear_q;
  logic [3:0]  period_clear_q;
  logic [9:0]  width_buf_q;
  logic [3:0]  mode_prev_q;
  logic        cmp_eq_q;
  logic        cap_s1_q;
  logic        cap_s2_q;
  logic        cap_s3_q;
  logic [3:0]  pre_cnt_q;

  logic         setup;
  logic         mapped;
  logic         wr_fire;
  logic [7:0]   rd_byte;
  logic         ctrl_en;
  logic [3:0]   act_mode;
  ccpts_class_t cls;
  logic         active;
  logic         entering;
  logic [1:0]   own_sel;
  ccpts_ptmr_t  sel_tmr;
  logic [9:0]   width_next;
  logic         period_hit;
  logic         tb_match;
  logic         cmp_eq;
  logic         match_evt;
  logic         rise;
  logic         fall;
  logic         cap_edge;
  logic [3:0]   pre_last;
  logic         cap_evt;

  // Bus decode
  assign setup   = psel & ~penable;
  assign mapped  = (paddr == OFS_CONTROL) || (paddr == OFS_TSEL_ONE) ||
                   (paddr == OFS_TSEL_TWO) || (paddr == OFS_VAL_LOW) ||
                   (paddr == OFS_VAL_HIGH);
  assign wr_fire = psel & penable & pready_q & pwrite & mapped;

  // Read view; output level is live, bit 6 and upper select bits are zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (paddr)
      OFS_CONTROL:  rd_byte = {control_q[EN_BIT], 1'b0, out_q, control_q[ALIGN_BIT:0]};
      OFS_TSEL_ONE: rd_byte = tsel_one_q & TSEL_WMASK;
      OFS_TSEL_TWO: rd_byte = tsel_two_q & TSEL_WMASK;
      OFS_VAL_LOW:  rd_byte = val_low_q;
      OFS_VAL_HIGH: rd_byte = val_high_q;
      default:      rd_byte = 8'h00;
    endcase
  end

  // Answer is prepared in setup, so every access completes with no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= RDATA_ZERO;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Control and timer-select registers; any reset clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q  <= RST_REG;
      tsel_one_q <= RST_REG;
      tsel_two_q <= RST_REG;
    end else if (wr_fire) begin
      if (paddr == OFS_CONTROL) begin
        control_q <= pwdata[7:0] & CTRL_WMASK;
      end
      if (paddr == OFS_TSEL_ONE) begin
        tsel_one_q <= pwdata[7:0] & TSEL_WMASK;
      end
      if (paddr == OFS_TSEL_TWO) begin
        tsel_two_q <= pwdata[7:0] & TSEL_WMASK;
      end
    end
  end

  // Mode decode; disabled unit behaves as mode off
  assign ctrl_en  = control_q[EN_BIT];
  assign act_mode = ctrl_en ? control_q[MODE_MSB:0] : MODE_OFF;
  assign active   = (act_mode != MODE_OFF);
  assign entering = (act_mode != mode_prev_q);

  always_comb begin
    cls = cls_off;
    if (act_mode[3:2] == MODE_PWM_TOP) begin
      cls = cls_pwm;
    end else if (act_mode[3] || act_mode == MODE_TGL || act_mode == MODE_TGL_CLR) begin
      cls = cls_compare;
    end else if (active) begin
      cls = cls_capture;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_prev_q <= MODE_OFF;
    end else begin
      mode_prev_q <= act_mode;
    end
  end

  // Timer choice for this unit's own channel
  always_comb begin
    unique case (OWN_CHANNEL)
      1:       own_sel = tsel_one_q[TSEL_MID_LSB +: 2];
      2:       own_sel = tsel_one_q[TSEL_HI_LSB +: 2];
      default: own_sel = tsel_one_q[TSEL_LO_LSB +: 2];
    endcase
  end

  assign sel_tmr = period_timers[own_sel];

  // Width assembly by alignment
  assign width_next = control_q[ALIGN_BIT] ? {val_high_q, val_low_q[7:6]}
                                         : {val_high_q[1:0], val_low_q};

  // Period end is the increment taken while count sits on its period
  assign period_hit = (cls == cls_pwm) && sel_tmr.inc &&
                      (sel_tmr.count == sel_tmr.period);
  // Time base built from pclk-driven count and sub bits; no other clock
  assign tb_match = ({sel_tmr.count, sel_tmr.sub} == width_buf_q);

  // Width buffer only reloads at period end, so writes never glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_buf_q <= 10'h000;
    end else if (!active) begin
      width_buf_q <= 10'h000;
    end else if (period_hit) begin
      width_buf_q <= width_next;
    end
  end

  // Clear request to the selected period timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_clear_q <= 4'h0;
    end else begin
      period_clear_q <= period_hit ? (4'h1 << own_sel) : 4'h0;
    end
  end

  // Compare match fires once when equality begins
  assign cmp_eq    = (companion_wide_timer == {val_high_q, val_low_q});
  assign match_evt = (cls == cls_compare) && cmp_eq && !cmp_eq_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_eq_q <= 1'b0;
    end else begin
      cmp_eq_q <= (cls == cls_compare) && cmp_eq;
    end
  end

  // Capture pin synchroniser, third stage for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_s1_q <= 1'b0;
      cap_s2_q <= 1'b0;
      cap_s3_q <= 1'b0;
    end else begin
      cap_s1_q <= capture_pin;
      cap_s2_q <= cap_s1_q;
      cap_s3_q <= cap_s2_q;
    end
  end

  assign rise = cap_s2_q & ~cap_s3_q;
  assign fall = ~cap_s2_q & cap_s3_q;

  always_comb begin
    cap_edge = 1'b0;
    pre_last = PRE_LAST_1;
    unique case (act_mode)
      MODE_CAP_BOTH: cap_edge = rise | fall;
      MODE_CAP_FALL: cap_edge = fall;
      MODE_CAP_R1:   cap_edge = rise;
      MODE_CAP_R4: begin
        cap_edge = rise;
        pre_last = PRE_LAST_4;
      end
      MODE_CAP_R16: begin
        cap_edge = rise;
        pre_last = PRE_LAST_16;
      end
      default: cap_edge = 1'b0;
    endcase
  end

  assign cap_evt = (cls == cls_capture) && cap_edge && (pre_cnt_q == pre_last);

  // Prescaler restarts on any mode change so counts start clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_q <= 4'h0;
    end else if (cls != cls_capture || entering) begin
      pre_cnt_q <= 4'h0;
    end else if (cap_edge) begin
      pre_cnt_q <= (pre_cnt_q == pre_last) ? 4'h0 : pre_cnt_q + 4'h1;
    end
  end

  // Value registers; a capture beats a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_low_q  <= RST_REG;
      val_high_q <= RST_REG;
    end else if (cap_evt) begin
      val_low_q  <= companion_wide_timer[7:0];
      val_high_q <= companion_wide_timer[15:8];
    end else if (wr_fire) begin
      if (paddr == OFS_VAL_LOW) begin
        val_low_q <= pwdata[7:0];
      end
      if (paddr == OFS_VAL_HIGH) begin
        val_high_q <= pwdata[7:0];
      end
    end
  end

  // Unit output level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    end else if (!active) begin
      out_q <= 1'b0;
    end else begin
      unique case (cls)
        cls_pwm: begin
          if (period_hit) begin
            out_q <= (width_next != 10'h000);
          end else if (tb_match) begin
            out_q <= 1'b0;
          end
        end
        cls_compare: begin
          if (entering && (act_mode == MODE_SET || act_mode == MODE_CLR)) begin
            out_q <= 1'b1;
          end else if (match_evt) begin
            unique case (act_mode)
              MODE_SET:                 out_q <= 1'b1;
              MODE_CLR:                 out_q <= 1'b0;
              MODE_PULSE, MODE_PULSE_CL: out_q <= 1'b1;
              default:                  out_q <= ~out_q;
            endcase
          end else if (act_mode == MODE_PULSE || act_mode == MODE_PULSE_CL) begin
            out_q <= 1'b0;
          end
        end
        default: out_q <= 1'b0;
      endcase
    end
  end

  // Companion timer clear and pin direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_clear_q <= 1'b0;
      oe_q         <= 1'b0;
    end else begin
      comp_clear_q <= match_evt &&
                      (act_mode == MODE_PULSE_CL || act_mode == MODE_TGL_CLR);
      oe_q         <= active && (cls != cls_capture);
    end
  end

  // Outputs, all from flip-flops
  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign unit_out        = out_q;
  assign pin_out         = out_q;
  assign pin_oe          = oe_q;
  assign consumers       = {8{out_q}};
  assign companion_clear = comp_clear_q;
  assign period_clear    = period_clear_q;
  assign timer_choices   = {tsel_one_q[5:0], tsel_two_q[5:0]};

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_capture_load: assert property (cap_evt |=>
    {val_high_q, val_low_q} == $past(companion_wide_timer))
    else $error("capture did not load companion count");

  chk_pwm_period_set: assert property (period_hit && width_next != 10'h000 |=>
    out_q && width_buf_q == $past(width_next))
    else $error("period end did not set output and latch width");

  chk_pwm_width_clr: assert property ((cls == cls_pwm) && active && !period_hit && tb_match
    |=> !out_q)
    else $error("width match did not clear output");

  chk_period_clear_sel: assert property (period_hit |=>
    period_clear_q == (4'h1 << $past(own_sel)) ##1 period_clear_q == 4'h0 || $past(period_hit))
    else $error("wrong period timer cleared");

  chk_ctrl_readback: assert property (setup && !pwrite && paddr == OFS_CONTROL |=>
    prdata_q[RSV_BIT] == 1'b0 && prdata_q[OUT_BIT] == $past(out_q) && pready_q)
    else $error("control readback wrong");

  chk_toggle_match: assert property (match_evt &&
    (act_mode == MODE_TGL || act_mode == MODE_TGL_CLR) |=> out_q != $past(out_q))
    else $error("toggle did not flip output");

  chk_pulse_shape: assert property (match_evt && act_mode == MODE_PULSE
    && control_q == $past(control_q) |=> out_q ##1 !out_q)
    else $error("pulse not one cycle wide");

  chk_companion_clr: assert property (match_evt && act_mode == MODE_PULSE_CL
    |=> companion_clear)
    else $error("companion clear missing");

  chk_prescale_16: assert property ((cls == cls_capture) && !entering && cap_edge &&
    act_mode == MODE_CAP_R16 && pre_cnt_q != 4'hF |=> pre_cnt_q == $past(pre_cnt_q) + 4'h1)
    else $error("prescaler skipped an edge");

  chk_off_quiet: assert property (!active |=> !out_q && !oe_q)
    else $error("unit active while off");

  chk_set_entry: assert property (entering && act_mode == MODE_CLR && !match_evt
    |=> out_q)
    else $error("mode entry did not set output");

  chk_disable_bit: assert property (!control_q[EN_BIT] |=>
    !out_q && !comp_clear_q && period_clear_q == 4'h0)
    else $error("unit running while disabled");

  cov_capture: cover property (cap_evt ##[1:200] cap_evt);
  cov_pwm_cycle: cover property (period_hit ##[1:600] (tb_match && out_q));
  cov_toggle: cover property (match_evt && act_mode == MODE_TGL);
  cov_read_ctrl: cover property (pready_q && !pwrite && paddr == OFS_CONTROL);

endmodule
`default_nettype wire

// [ccpts_pkg.sv]
// Notes on behaviour
// - Pulse timing derives only from system clock.
// - Reset restores registers; pin returns to input.
// - Pulse output feeds every internal consumer.
// - Control bit 7 enables the unit.
// - Control bit 5 shows output, read-only.
// - Alignment bit picks left or right width.
// - Mode 11xx selects pulse-width mode.
// - 1011 pulse plus timer clear; 1010 pulse.
// - 1001 sets on entry, clears on match.
// - 1000 sets on entry and on match.
// - Capture every 16th, 4th, each rising edge.
// - 0100 falling edges; 0011 both edges.
// - 0010 toggles; 0001 toggles and clears timer.
// - Mode 0000 turns unit off, resets state.
// - Select one bits 5-4 pick channel seven timer.
// - Bits 3-2, 1-0 pick channels two, one.
// - Select two picks pulse channels nine, four, three.
// - Unimplemented bits read as zero.
// - Low value byte captures or compares low.
// - High value byte captures or compares high.
// - Right alignment: width from low, high 1:0.
// - Left alignment: width from high, low 7:6.
// - Period end clears timer, latches width, sets output if width nonzero.
// - Time base equal to buffered width clears output.
`default_nettype none
package ccpts_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_TSEL_ONE = 8'h04;
  localparam logic [7:0] OFS_TSEL_TWO = 8'h08;
  localparam logic [7:0] OFS_VAL_LOW  = 8'h0C;
  localparam logic [7:0] OFS_VAL_HIGH = 8'h10;

  // Reset values and writable masks
  localparam logic [7:0] RST_REG       = 8'h00;
  localparam logic [7:0] CTRL_WMASK    = 8'h9F;
  localparam logic [7:0] TSEL_WMASK    = 8'h3F;
  localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

  // Control field positions
  localparam int EN_BIT   = 7;
  localparam int RSV_BIT  = 6;
  localparam int OUT_BIT  = 5;
  localparam int ALIGN_BIT = 4;
  localparam int MODE_MSB = 3;

  // Timer-select field positions (low bit of each pair)
  localparam int TSEL_HI_LSB  = 4;
  localparam int TSEL_MID_LSB = 2;
  localparam int TSEL_LO_LSB  = 0;

  // Mode codes
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_TGL_CLR  = 4'h1;
  localparam logic [3:0] MODE_TGL      = 4'h2;
  localparam logic [3:0] MODE_CAP_BOTH = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_R1   = 4'h5;
  localparam logic [3:0] MODE_CAP_R4   = 4'h6;
  localparam logic [3:0] MODE_CAP_R16  = 4'h7;
  localparam logic [3:0] MODE_SET      = 4'h8;
  localparam logic [3:0] MODE_CLR      = 4'h9;
  localparam logic [3:0] MODE_PULSE    = 4'hA;
  localparam logic [3:0] MODE_PULSE_CL = 4'hB;
  localparam logic [1:0] MODE_PWM_TOP  = 2'h3;

  // Capture prescaler terminal counts
  localparam logic [3:0] PRE_LAST_1  = 4'h0;
  localparam logic [3:0] PRE_LAST_4  = 4'h3;
  localparam logic [3:0] PRE_LAST_16 = 4'hF;

  localparam int NUM_PTMR = 4;

  typedef enum logic [1:0] {cls_off, cls_capture, cls_compare, cls_pwm} ccpts_class_t;

  // One 8-bit period timer as seen by the unit
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
    logic [1:0] sub;
    logic       inc;
  } ccpts_ptmr_t;

  // Internal consumers of the unit output
  typedef struct packed {
    logic adc_trigger;
    logic complementary_output_generator;
    logic ramp_generator;
    logic signal_modulator;
    logic logic_cell;
    logic amp_override;
    logic period_timer_reset;
    logic pin_select;
  } ccpts_route_t;

  // Timer choices for all channels
  typedef struct packed {
    logic [1:0] channel_seven_timer_choice;
    logic [1:0] channel_two_timer_choice;
    logic [1:0] channel_one_timer_choice;
    logic [1:0] pwm_nine_timer_choice;
    logic [1:0] pwm_four_timer_choice;
    logic [1:0] pwm_three_timer_choice;
  } ccpts_tsel_t;

endpackage
`default_nettype wire

// [ccpts_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module ccpts_partner
  import ccpts_pkg::*;
#(
  parameter int CWRAP = 512
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  companion_clear,
  input  wire logic [NUM_PTMR-1:0]   period_clear,
  output ccpts_ptmr_t [NUM_PTMR-1:0] period_timers,
  output logic [15:0]                companion_wide_timer
);
  logic [7:0] cnt_q [NUM_PTMR];
  logic [1:0] sub_q [NUM_PTMR];

  // Short wrap keeps compare matches a few hundred cycles apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      companion_wide_timer <= 16'h0000;
    end else if (companion_clear || companion_wide_timer == 16'(CWRAP - 1)) begin
      companion_wide_timer <= 16'h0000;
    end else begin
      companion_wide_timer <= companion_wide_timer + 16'h0001;
    end
  end

  // Timer view: sub is the low time-base pair, inc on its wrap
  always_comb begin
    for (int i = 0; i < NUM_PTMR; i++) begin
      period_timers[i].count  = cnt_q[i];
      period_timers[i].period = 8'(3 + 2 * i);
      period_timers[i].sub    = sub_q[i];
      period_timers[i].inc    = (sub_q[i] == 2'h3);
    end
  end

  // Reload at period end; a clear request is honoured too
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < NUM_PTMR; i++) begin
      if (!presetn) begin
        cnt_q[i] <= 8'h00;
        sub_q[i] <= 2'h0;
      end else begin
        sub_q[i] <= sub_q[i] + 2'h1;
        if (period_clear[i] || (sub_q[i] == 2'h3 && cnt_q[i] == 8'(3 + 2 * i))) begin
          cnt_q[i] <= 8'h00;
        end else if (sub_q[i] == 2'h3) begin
          cnt_q[i] <= cnt_q[i] + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [ccpts_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ccpts_tb;
  import ccpts_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, seed = 32'h0000_0027;
  logic pready, pslverr, capture_pin = 1'b0, unit_out, pin_out, pin_oe, companion_clear, e, f;
  ccpts_ptmr_t [NUM_PTMR-1:0] period_timers;
  logic [15:0] companion_wide_timer, v, c, q16;
  logic [NUM_PTMR-1:0] period_clear;
  ccpts_route_t consumers;
  ccpts_tsel_t timer_choices;
  logic [7:0] q, hi, lo;
  logic [3:0] m;
  logic [9:0] w;
  logic [31:0] r, r2;
  logic [7:0] ofs [5] = '{OFS_CONTROL, OFS_TSEL_ONE, OFS_TSEL_TWO, OFS_VAL_LOW, OFS_VAL_HIGH};
  logic [3:0] cm [6] = '{MODE_TGL_CLR, MODE_TGL, MODE_SET, MODE_CLR, MODE_PULSE, MODE_PULSE_CL};
  int ct [5] = '{1, 2, 1, 7, 31};
  int n_fail = 0, n_checks = 0, n, p, h;

  ccpts_unit #(.OWN_CHANNEL(0)) ccpts_unit_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .period_timers(period_timers), .companion_wide_timer(companion_wide_timer),
    .capture_pin(capture_pin), .unit_out(unit_out), .pin_out(pin_out), .pin_oe(pin_oe),
    .consumers(consumers), .companion_clear(companion_clear), .period_clear(period_clear),
    .timer_choices(timer_choices));

  ccpts_partner ccpts_partner_i (
    .pclk(pclk), .presetn(presetn), .companion_clear(companion_clear),
    .period_clear(period_clear), .period_timers(period_timers),
    .companion_wide_timer(companion_wide_timer));

  // Free-running system clock
  always #5 pclk = ~pclk;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    n_checks++;
    if (g !== x) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic tmo();
    n_fail++;
    $display("BAD t=%0t wait ran out %h %h", $time, 1'b0, 1'b1);
    end_sim();
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // One bus transfer; held until pready, then one idle cycle
  task automatic apb(input logic [7:0] a, input logic wr_en, input logic [7:0] dat,
                     output logic [7:0] rq, output logic er);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= {24'h000000, dat};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) tmo();
    rq = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    logic [7:0] t;
    logic te;
    apb(a, 1'b1, dat, t, te);
    chk(16'(te), 16'h0000);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] rq);
    logic te;
    apb(a, 1'b0, 8'h00, rq, te);
    chk(16'(te), 16'h0000);
  endtask

  task automatic rdall(input logic [7:0] x [5]);
    logic [7:0] t;
    foreach (ofs[i]) begin
      rd(ofs[i], t);
      chk(16'(t), 16'(x[i]));
    end
  endtask

  task automatic rdv(output logic [15:0] val);
    rd(OFS_VAL_LOW, val[7:0]);
    rd(OFS_VAL_HIGH, val[15:8]);
  endtask

  // Wait for the selected timer's clear pulse, seen mid-cycle
  task automatic waitpc(input int k);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (period_clear[k] !== 1'b1 && n < 200);
    if (n >= 200) tmo();
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdall('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    chk(16'(pin_oe), 16'h0000);
    // Reserved and read-only bits ignore writes; enable low keeps output off
    r = xs();
    r2 = xs();
    wr(OFS_TSEL_ONE, r[7:0]);
    wr(OFS_TSEL_TWO, r2[7:0]);
    wr(OFS_VAL_LOW, r[15:8]);
    wr(OFS_VAL_HIGH, r2[15:8]);
    wr(OFS_CONTROL, 8'h68);
    rdall('{8'h08, r[7:0] & 8'h3F, r2[7:0] & 8'h3F, r[15:8], r2[15:8]});
    chk(16'(timer_choices), {4'h0, r[5:0], r2[5:0]});
    chk(16'(unit_out), 16'h0000);
    apb(8'h14, 1'b1, 8'hAA, q, e);
    chk(16'(e), 16'h0001);
    apb(8'h14, 1'b0, 8'h00, q, e);
    chk(16'(e), 16'h0001);
    $display("registers done");
    // Every compare mode from a cleared state
    foreach (cm[j]) begin
      m = cm[j];
      wr(OFS_CONTROL, 8'h00);
      // Keep the match well clear of zero, so a cleared timer cannot match again soon
      v = ((companion_wide_timer + 16'h0064) & 16'h01FF) | 16'h0040;
      wr(OFS_VAL_LOW, v[7:0]);
      wr(OFS_VAL_HIGH, v[15:8]);
      wr(OFS_CONTROL, {4'h8, m});
      @(posedge pclk);
      #1;
      chk({unit_out, pin_oe}, {m == MODE_SET || m == MODE_CLR, 1'b1});
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (companion_wide_timer !== v && n < 600);
      if (n >= 600) tmo();
      @(posedge pclk);
      #1;
      chk({unit_out, companion_clear}, {m != MODE_CLR, m == MODE_TGL_CLR || m == MODE_PULSE_CL});
      @(posedge pclk);
      #1;
      e = (m != MODE_CLR) && (m < MODE_PULSE);
      chk({unit_out, companion_clear}, {e, 1'b0});
      @(posedge pclk);
      rd(OFS_CONTROL, q);
      chk(16'(q), 16'({2'b10, e, 1'b0, m}));
    end
    $display("compare done");
    // Capture modes: one edge short of the count, then the qualifying edge
    for (int j = 0; j < 5; j++) begin
      wr(OFS_CONTROL, 8'h00);
      capture_pin <= 1'b0;
      wr(OFS_VAL_LOW, 8'hFF);
      wr(OFS_VAL_HIGH, 8'hFF);
      wr(OFS_CONTROL, 8'h83 + 8'(j));
      repeat (4) @(posedge pclk);
      for (int i = 1; i < ct[j]; i++) begin
        capture_pin <= ~capture_pin;
        repeat (4) @(posedge pclk);
      end
      rdv(q16);
      chk(q16, 16'hFFFF);
      c = companion_wide_timer;
      capture_pin <= ~capture_pin;
      repeat (8) @(posedge pclk);
      rdv(q16);
      // Pin seen three edges later; companion wraps at 512
      chk(q16, (c + 16'h0003) & 16'h01FF);
    end
    $display("capture done");
    // Pulse width per period timer, both alignments, zero and over-range widths
    for (int k = 0; k < NUM_PTMR; k++) begin
      p = 4 * (4 + 2 * k);
      w = (k == 0) ? 10'h000 : (k == 3) ? 10'h3FF : 10'(1 + xs() % (p - 2));
      f = k[0];
      r = xs();
      hi = f ? w[9:2] : {r[7:2], w[9:8]};
      lo = f ? {w[1:0], r[5:0]} : w[7:0];
      wr(OFS_TSEL_ONE, {r[7:2], 2'(k)});
      wr(OFS_VAL_LOW, lo);
      wr(OFS_VAL_HIGH, hi);
      wr(OFS_CONTROL, {3'b100, f, 2'b11, r[9:8]});
      waitpc(k);
      waitpc(k);
      chk(16'(period_clear), 16'(4'h1 << k));
      h = 0;
      for (int i = 0; i < p; i++) begin
        if (i > 0) @(negedge pclk);
        h += int'(unit_out);
        chk(16'({consumers, pin_out}), 16'({9{unit_out}}));
      end
      chk(16'(h), 16'(w == 0 ? 0 : w >= p ? p : w + 1));
      @(posedge pclk);
    end
    $display("pulse width done");
    // Reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk({unit_out, pin_oe, period_clear}, 16'h0000);
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdall('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    $display("reset done");
    end_sim();
  end
endmodule
`default_nettype wire
